// file: core/sdp_pkg.sv
// Constants and types of the dual-element SIMD datapath
// Function
// - First element runs unless second-only; second needs enable
// - SIMD: same instruction, own register operands
// - Second-element-only instructions leave first untouched
// - SIMD memory access moves two values
// - Multiplier works in parallel with ALU or shifter (one shared op field)
// - Fixed, single, extended, double formats handled
// - One instruction starts ALU and multiply together
// - Independent operations finish in one cycle
// - Dependent float result needs two cycles
// - Double precision takes two to six cycles
// - Interlock stalls issue on data dependency
// - Sixteen primary, sixteen secondary data registers each
// - Register file stages bus data, keeps results
// - Mode bits select secondary copies; primary at reset
// - Four universal registers: set, clear, toggle, test, XOR
// - Exchange register bridges buses, adjusts widths
// - Thirty-two circular buffers, half per bank
// - Pointers wrap automatically, any start address
package sdp_pkg;
  localparam int DATA_W = 40;
  localparam int BUS_W = 64;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 32;
  localparam int MRF_W = 80;
  localparam int REG_CNT = 16;
  localparam int ELEM_CNT = 2;
  localparam int BANK_CNT = 2;
  localparam int UB_CNT = 4;
  localparam int AG_CNT = 2;
  localparam int BUF_CNT = 8;
  localparam logic [2:0] LAT_ONE = 3'h1;
  localparam logic [2:0] LAT_FLOAT = 3'h2;
  localparam logic [2:0] LAT_DBL_ALU = 3'h2;
  localparam logic [2:0] LAT_DBL_SHIFT = 3'h4;
  localparam logic [2:0] LAT_DBL_MUL = 3'h6;
  localparam logic [DATA_W-1:0] REG_RESET = 40'h0;
  localparam logic [WORD_W-1:0] UB_RESET = 32'h0;
  localparam logic [BUS_W-1:0] PX_RESET = 64'h0;
  typedef enum logic [3:0] {ALU_NOP, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS,
    SH_LEFT, SH_RIGHT, SH_ARITH} sdp_alu_e;
  typedef enum logic [1:0] {FMT_FIXED, FMT_SINGLE, FMT_EXT, FMT_DOUBLE} sdp_fmt_e;
  typedef enum logic [1:0] {MEM_NONE, MEM_LOAD, MEM_STORE} sdp_mem_e;
  typedef enum logic [2:0] {UB_NOP, UB_WRITE, UB_SET, UB_CLEAR, UB_TOGGLE, UB_TEST,
    UB_XOR} sdp_ub_e;
  typedef enum logic [2:0] {PX_NOP, PX_FROM_PM, PX_FROM_DM, PX_FROM_REG, PX_TO_REG} sdp_px_e;
  typedef logic [3:0] sdp_idx_t;
  typedef struct packed {
    logic secondEn;
    logic dataBank;
    logic agBank;
    logic mulBank;
  } sdp_mode_s;
  typedef struct packed {
    sdp_alu_e aluOp;
    sdp_idx_t aluDst;
    sdp_idx_t aluSrcA;
    sdp_idx_t aluSrcB;
    logic mulEn;
    sdp_idx_t mulDst;
    sdp_idx_t mulSrcA;
    sdp_idx_t mulSrcB;
    sdp_fmt_e fmt;
    logic yOnly;
    sdp_mem_e memOp;
    sdp_idx_t memReg;
    logic agGen;
    logic [2:0] agBuf;
    sdp_px_e pxOp;
    sdp_idx_t pxReg;
  } sdp_instr_s;
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] length;
    logic [ADDR_W-1:0] modify;
    logic [ADDR_W-1:0] index;
  } sdp_buf_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic pair;
    logic [ADDR_W-1:0] addr;
    logic [BUS_W-1:0] wdata;
  } sdp_mem_s;
  typedef struct packed {
    logic zero;
    logic neg;
  } sdp_flags_s;
endpackage

// file: core/sdp_datapath.sv
// Dual-element SIMD compute datapath with exchange, universal and address registers
`timescale 1ns/100ps
`default_nettype none
module sdp_datapath
  import sdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire sdp_mode_s mode,
  input wire logic issueValid,
  input wire sdp_instr_s issue,
  output logic issueReady,
  input wire logic [BUS_W-1:0] memRData,
  input wire logic [BUS_W-1:0] pmBusIn,
  input wire logic [BUS_W-1:0] dmBusIn,
  input wire logic bufCfgWe,
  input wire logic bufCfgGen,
  input wire logic bufCfgBank,
  input wire logic [2:0] bufCfgBuf,
  input wire sdp_buf_s bufCfg,
  input wire sdp_ub_e ubOp,
  input wire logic [1:0] ubSel,
  input wire logic [WORD_W-1:0] ubOperand,
  output sdp_mem_s memReq,
  output sdp_flags_s firstFlags,
  output sdp_flags_s secondFlags,
  output logic [BUS_W-1:0] pxData,
  output logic [WORD_W-1:0] ubData,
  output logic ubTestHit
);
  // ************************************************
  // Helper functions
  // ************************************************
  function automatic logic [DATA_W-1:0] fmtMask(sdp_fmt_e f, logic [DATA_W-1:0] v);
    fmtMask = (f == FMT_FIXED || f == FMT_SINGLE) ? {8'h00, v[WORD_W-1:0]} : v;
  endfunction

  // Sign sits at bit 31 for the 32-bit formats; the masked top bits would never show it
  function automatic logic signOf(sdp_fmt_e f, logic [DATA_W-1:0] v);
    signOf = (f == FMT_FIXED || f == FMT_SINGLE) ? v[WORD_W-1] : v[DATA_W-1];
  endfunction

  function automatic logic [DATA_W-1:0] aluCalc(sdp_alu_e op, logic [DATA_W-1:0] a,
                                                logic [DATA_W-1:0] b);
    unique case (op)
      ALU_ADD: aluCalc = a + b;
      ALU_SUB: aluCalc = a - b;
      ALU_AND: aluCalc = a & b;
      ALU_OR: aluCalc = a | b;
      ALU_XOR: aluCalc = a ^ b;
      ALU_PASS: aluCalc = a;
      SH_LEFT: aluCalc = a << b[5:0];
      SH_RIGHT: aluCalc = a >> b[5:0];
      SH_ARITH: aluCalc = $signed(a) >>> b[5:0];
      default: aluCalc = a;
    endcase
  endfunction

  function automatic logic readsReg(sdp_instr_s i, sdp_idx_t r);
    readsReg = (i.aluOp != ALU_NOP && (i.aluSrcA == r || i.aluSrcB == r))
      || (i.mulEn && (i.mulSrcA == r || i.mulSrcB == r))
      || (i.memOp == MEM_STORE && i.memReg == r)
      || (i.pxOp == PX_FROM_REG && i.pxReg == r);
  endfunction

  function automatic logic writesReg(sdp_instr_s i, sdp_idx_t r);
    writesReg = (i.aluOp != ALU_NOP && i.aluDst == r) || (i.mulEn && i.mulDst == r)
      || (i.memOp == MEM_LOAD && i.memReg == r) || (i.pxOp == PX_TO_REG && i.pxReg == r);
  endfunction

  // Completion time by format and unit
  function automatic logic [2:0] latencyOf(sdp_instr_s i);
    if (i.fmt == FMT_FIXED || (i.aluOp == ALU_NOP && !i.mulEn))
      latencyOf = LAT_ONE;
    else if (i.fmt != FMT_DOUBLE)
      latencyOf = LAT_FLOAT;
    else if (i.mulEn)
      latencyOf = LAT_DBL_MUL;
    else if (i.aluOp >= SH_LEFT)
      latencyOf = LAT_DBL_SHIFT;
    else
      latencyOf = LAT_DBL_ALU;
  endfunction

  // Circular pointer step; start and length may be anything
  function automatic logic [ADDR_W-1:0] circNext(sdp_buf_s b);
    logic [ADDR_W:0] nxt;
    logic [ADDR_W:0] top;
    nxt = {1'b0, b.index} + {b.modify[ADDR_W-1], b.modify};
    top = {1'b0, b.base} + {1'b0, b.length};
    if (!b.modify[ADDR_W-1] && nxt >= top)
      nxt = nxt - {1'b0, b.length};
    else if (b.modify[ADDR_W-1] && nxt[ADDR_W-1:0] < b.base)
      nxt = nxt + {1'b0, b.length};
    circNext = nxt[ADDR_W-1:0];
  endfunction

  // ************************************************
  // State
  // ************************************************
  logic [DATA_W-1:0] rf [ELEM_CNT][BANK_CNT][REG_CNT];
  logic [MRF_W-1:0] mrf [ELEM_CNT][BANK_CNT];
  sdp_buf_s bufs [AG_CNT][BANK_CNT][BUF_CNT];
  logic [WORD_W-1:0] ubRegs [UB_CNT];
  logic pendValid;
  logic [2:0] pendCnt;
  sdp_instr_s pendIns;
  logic pendBank;
  logic pendMulBank;
  logic [ELEM_CNT-1:0] pendEl;
  logic [DATA_W-1:0] pendAlu [ELEM_CNT];
  logic [DATA_W-1:0] pendMul [ELEM_CNT];
  logic [BUS_W-1:0] pendProd [ELEM_CNT];
  logic ldValid;
  sdp_idx_t ldDst;
  logic ldBank;
  logic ldPair;
  logic [ELEM_CNT-1:0] ldEl;
  logic [ELEM_CNT-1:0] elemOn;
  logic [DATA_W-1:0] opA [ELEM_CNT];
  logic [DATA_W-1:0] opB [ELEM_CNT];
  logic [DATA_W-1:0] aluRes [ELEM_CNT];
  logic [DATA_W-1:0] mulRes [ELEM_CNT];
  logic [BUS_W-1:0] prod [ELEM_CNT];
  logic [DATA_W-1:0] stVal [ELEM_CNT];
  logic [2:0] curLat;
  logic fire;
  logic pendWb;
  logic rawPend;
  logic wawPend;
  logic busyPend;
  logic rawLoad;
  sdp_buf_s agCur;
  logic [ADDR_W-1:0] agNext;

  // ************************************************
  // Issue control and interlock
  // ************************************************
  // Second element only when enabled; y-only keeps the first idle
  assign elemOn[0] = !issue.yOnly;
  assign elemOn[1] = mode.secondEn;
  assign curLat = latencyOf(issue);
  assign pendWb = pendValid && pendCnt == LAT_ONE;
  // Banks are ignored here: a conservative stall is cheaper than a bank compare
  assign rawPend = pendValid && ((pendIns.aluOp != ALU_NOP && readsReg(issue, pendIns.aluDst))
    || (pendIns.mulEn && readsReg(issue, pendIns.mulDst)));
  assign wawPend = pendValid && !pendWb && ((pendIns.aluOp != ALU_NOP
    && writesReg(issue, pendIns.aluDst)) || (pendIns.mulEn && writesReg(issue, pendIns.mulDst)));
  assign busyPend = pendValid && !pendWb && curLat != LAT_ONE;
  assign rawLoad = ldValid && readsReg(issue, ldDst);
  assign issueReady = !(rawPend || wawPend || busyPend || rawLoad);
  assign fire = clkEn && issueValid && issueReady;

  // Both elements compute the same operation side by side on own operands
  always_comb
  begin
    for (int e = 0; e < ELEM_CNT; e++)
    begin
      opA[e] = rf[e][mode.dataBank][issue.aluSrcA];
      opB[e] = rf[e][mode.dataBank][issue.aluSrcB];
      stVal[e] = rf[e][mode.dataBank][issue.memReg];
      aluRes[e] = fmtMask(issue.fmt, aluCalc(issue.aluOp, opA[e], opB[e]));
      prod[e] = rf[e][mode.dataBank][issue.mulSrcA][WORD_W-1:0]
        * rf[e][mode.dataBank][issue.mulSrcB][WORD_W-1:0];
      mulRes[e] = fmtMask(issue.fmt, prod[e][DATA_W-1:0]);
    end
  end

  // ************************************************
  // Multi-cycle result slot
  // ************************************************
  // One slot; the next long op may load it on the slot's last cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendValid <= 1'b0;
      pendCnt <= 3'h0;
      pendIns <= '0;
      pendBank <= 1'b0;
      pendMulBank <= 1'b0;
      pendEl <= '0;
      for (int e = 0; e < ELEM_CNT; e++)
      begin
        pendAlu[e] <= REG_RESET;
        pendMul[e] <= REG_RESET;
        pendProd[e] <= '0;
      end
    end
    else if (clkEn)
    begin
      if (fire && curLat != LAT_ONE)
      begin
        pendValid <= 1'b1;
        pendCnt <= curLat - LAT_ONE;
        pendIns <= issue;
        pendBank <= mode.dataBank;
        pendMulBank <= mode.mulBank;
        pendEl <= elemOn;
        for (int e = 0; e < ELEM_CNT; e++)
        begin
          pendAlu[e] <= aluRes[e];
          pendMul[e] <= mulRes[e];
          pendProd[e] <= prod[e];
        end
      end
      else if (pendWb)
        pendValid <= 1'b0;
      else if (pendValid)
        pendCnt <= pendCnt - LAT_ONE;
    end
  end

  // ************************************************
  // Data registers, multiplier result registers, flags
  // ************************************************
  // Older results are written first so a newer write to the same slot wins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int e = 0; e < ELEM_CNT; e++)
        for (int k = 0; k < BANK_CNT; k++)
        begin
          mrf[e][k] <= '0;
          for (int r = 0; r < REG_CNT; r++)
            rf[e][k][r] <= REG_RESET;
        end
    end
    else if (clkEn)
    begin
      for (int e = 0; e < ELEM_CNT; e++)
      begin
        if (pendWb && pendEl[e])
        begin
          if (pendIns.aluOp != ALU_NOP)
            rf[e][pendBank][pendIns.aluDst] <= pendAlu[e];
          if (pendIns.mulEn)
          begin
            rf[e][pendBank][pendIns.mulDst] <= pendMul[e];
            mrf[e][pendMulBank] <= MRF_W'(pendProd[e]);
          end
        end
        if (ldValid && ldEl[e])
          rf[e][ldBank][ldDst] <= (e == 1 && ldPair) ? DATA_W'(memRData[BUS_W-1:WORD_W])
            : DATA_W'(memRData[WORD_W-1:0]);
        if (fire && elemOn[e] && curLat == LAT_ONE)
        begin
          if (issue.aluOp != ALU_NOP)
            rf[e][mode.dataBank][issue.aluDst] <= aluRes[e];
          if (issue.mulEn)
          begin
            rf[e][mode.dataBank][issue.mulDst] <= mulRes[e];
            mrf[e][mode.mulBank] <= MRF_W'(prod[e]);
          end
        end
        if (e == 0 && fire && elemOn[0] && issue.pxOp == PX_TO_REG)
          rf[0][mode.dataBank][issue.pxReg] <= pxData[DATA_W-1:0];
      end
    end
  end

  // Flags follow the ALU result at issue
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      firstFlags <= '0;
      secondFlags <= '0;
    end
    else if (fire && issue.aluOp != ALU_NOP)
    begin
      if (elemOn[0])
        firstFlags <= '{zero: aluRes[0] == '0, neg: signOf(issue.fmt, aluRes[0])};
      if (elemOn[1])
        secondFlags <= '{zero: aluRes[1] == '0, neg: signOf(issue.fmt, aluRes[1])};
    end
  end

  // ************************************************
  // Address generators and memory port
  // ************************************************
  assign agCur = bufs[issue.agGen][mode.agBank][issue.agBuf];
  assign agNext = circNext(agCur);

  // Configuration writes after the pointer step so software wins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int g = 0; g < AG_CNT; g++)
        for (int k = 0; k < BANK_CNT; k++)
          for (int b = 0; b < BUF_CNT; b++)
            bufs[g][k][b] <= '0;
    end
    else if (clkEn)
    begin
      if (fire && issue.memOp != MEM_NONE)
        bufs[issue.agGen][mode.agBank][issue.agBuf].index <= agNext;
      if (bufCfgWe)
        bufs[bufCfgGen][bufCfgBank][bufCfgBuf] <= bufCfg;
    end
  end

  // Read data returns in the same cycle as the registered request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memReq <= '0;
      ldValid <= 1'b0;
      ldDst <= '0;
      ldBank <= 1'b0;
      ldPair <= 1'b0;
      ldEl <= '0;
    end
    else if (clkEn)
    begin
      memReq.valid <= fire && issue.memOp != MEM_NONE;
      memReq.write <= issue.memOp == MEM_STORE;
      memReq.pair <= &elemOn;
      memReq.addr <= agCur.index;
      memReq.wdata <= (&elemOn) ? {stVal[1][WORD_W-1:0], stVal[0][WORD_W-1:0]}
        : {32'h0, stVal[issue.yOnly][WORD_W-1:0]};
      ldValid <= fire && issue.memOp == MEM_LOAD && (|elemOn);
      ldDst <= issue.memReg;
      ldBank <= mode.dataBank;
      ldPair <= &elemOn;
      ldEl <= elemOn;
    end
  end

  // ************************************************
  // Universal and exchange registers
  // ************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int u = 0; u < UB_CNT; u++)
        ubRegs[u] <= UB_RESET;
      ubTestHit <= 1'b0;
      ubData <= UB_RESET;
    end
    else if (clkEn)
    begin
      unique case (ubOp)
        UB_WRITE: ubRegs[ubSel] <= ubOperand;
        UB_SET: ubRegs[ubSel] <= ubRegs[ubSel] | ubOperand;
        UB_CLEAR: ubRegs[ubSel] <= ubRegs[ubSel] & ~ubOperand;
        UB_TOGGLE: ubRegs[ubSel] <= ubRegs[ubSel] ^ ubOperand;
        UB_XOR: ubRegs[ubSel] <= ubRegs[ubSel] ^ ubOperand;
        UB_TEST: ubTestHit <= (ubRegs[ubSel] & ubOperand) == ubOperand;
        default: ;
      endcase
      ubData <= ubRegs[ubSel];
    end
  end

  // Narrow register data is zero-extended into the wide exchange word
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pxData <= PX_RESET;
    else if (fire)
    begin
      unique case (issue.pxOp)
        PX_FROM_PM: pxData <= pmBusIn;
        PX_FROM_DM: pxData <= dmBusIn;
        PX_FROM_REG: pxData <= BUS_W'(opX(issue.pxReg));
        default: ;
      endcase
    end
  end

  function automatic logic [DATA_W-1:0] opX(sdp_idx_t r);
    opX = rf[0][mode.dataBank][r];
  endfunction

  // ************************************************
  // Checks
  // ************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence slotCountdown;
    pendValid [*5];
  endsequence

  firstElem_run_a: assert property ((fire && !issue.yOnly && curLat == LAT_ONE
    && issue.aluOp != ALU_NOP && !issue.mulEn && issue.pxOp != PX_TO_REG)
    |=> rf[0][$past(mode.dataBank)][$past(issue.aluDst)] == $past(aluRes[0]))
    else $error("first element result not written");
  second_idle_a: assert property (!mode.secondEn |=> secondFlags == $past(secondFlags))
    else $error("disabled second element changed flags");
  yonly_keeps_a: assert property (fire && issue.yOnly |=> firstFlags == $past(firstFlags))
    else $error("second-only instruction touched first element");
  simd_pair_a: assert property ((fire && issue.memOp != MEM_NONE && mode.secondEn
    && !issue.yOnly) |=> memReq.valid && memReq.pair)
    else $error("SIMD access did not move two values");
  float_twocyc_a: assert property ((fire && curLat == LAT_FLOAT)
    |=> pendValid && pendCnt == LAT_ONE)
    else $error("float result slot wrong");
  dbl_latency_a: assert property ((fire && curLat == LAT_DBL_MUL) |=> slotCountdown)
    else $error("double multiply finished early");
  dep_stall_a: assert property ((pendValid && issueValid && pendIns.aluOp != ALU_NOP
    && issue.aluOp != ALU_NOP && issue.aluSrcA == pendIns.aluDst) |-> !fire)
    else $error("dependent issue not stalled");
  circ_wrap_a: assert property ((fire && issue.memOp != MEM_NONE
    && agCur.index + agCur.modify == agCur.base + agCur.length && !agCur.modify[ADDR_W-1])
    |-> agNext == agCur.base)
    else $error("circular pointer did not wrap");
  ub_set_a: assert property ((clkEn && ubOp == UB_SET)
    |=> ubRegs[$past(ubSel)] == ($past(ubRegs[ubSel]) | $past(ubOperand)))
    else $error("universal set wrong");
  px_load_a: assert property ((fire && issue.pxOp == PX_FROM_PM) |=> pxData == $past(pmBusIn))
    else $error("exchange register load wrong");
  mul_bank_a: assert property ((fire && issue.mulEn && curLat == LAT_ONE && !issue.yOnly)
    |=> mrf[0][$past(mode.mulBank)] == MRF_W'($past(prod[0])))
    else $error("multiplier result bank wrong");
endmodule // sdp_datapath
`default_nettype wire

// file: tb/sdp_mem_model.sv
// Memory partner that answers the datapath's load and store requests
`timescale 1ns/100ps
`default_nettype none
module sdp_mem_model
  import sdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sdp_mem_s memReq,
  output logic [BUS_W-1:0] memRData
);
  // ****************************************
  // Small word store
  // ****************************************
  logic [BUS_W-1:0] store [16];
  // Preset words for the paired loads
  initial
  begin
    foreach (store[i])
      store[i] = '0;
    store[8] = 64'h0000000a_00000001;
    store[9] = 64'h00000005_00000003;
    store[10] = 64'h00000007_00000002;
  end
  // Data stands only while the read request does; junk otherwise, so a late sample cannot pass
  assign memRData = (rst_n && memReq.valid && !memReq.write) ? store[memReq.addr[3:0]]
    : ~store[memReq.addr[3:0]];
  // Stores land in the same array
  always @(posedge core_clk)
  begin
    if (memReq.valid && memReq.write)
      store[memReq.addr[3:0]] <= memReq.wdata;
  end
endmodule // sdp_mem_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the dual-element SIMD datapath
`timescale 1ns/100ps
`default_nettype none
module tb
  import sdp_pkg::*;
;
  logic core_clk, rst_n, clkEn, issueValid, issueReady, bufCfgWe, bufCfgGen, bufCfgBank;
  logic ubTestHit;
  logic [2:0] bufCfgBuf;
  logic [1:0] ubSel;
  logic [WORD_W-1:0] ubOperand, ubData;
  logic [BUS_W-1:0] memRData, pmBusIn, dmBusIn, pxData;
  sdp_mode_s mode;
  sdp_instr_s issue, w;
  sdp_buf_s bufCfg;
  sdp_ub_e ubOp;
  sdp_mem_s memReq;
  sdp_flags_s firstFlags, secondFlags;
  int errors, num_checks, s, sa, k;
  sdp_fmt_e lf [6] = '{FMT_FIXED, FMT_SINGLE, FMT_EXT, FMT_DOUBLE, FMT_DOUBLE, FMT_DOUBLE};
  sdp_alu_e lo [6] = '{ALU_ADD, ALU_ADD, ALU_ADD, ALU_ADD, SH_LEFT, ALU_NOP};
  bit lm [6] = '{0, 0, 0, 0, 0, 1};
  int le [6] = '{0, 1, 1, 1, 3, 5};
  sdp_ub_e uo [7] = '{UB_WRITE, UB_SET, UB_CLEAR, UB_TOGGLE, UB_XOR, UB_TEST, UB_TEST};
  logic [31:0] uv [7] = '{32'hf0f0, 32'h000f, 32'hf000, 32'h0101, 32'h00ff, 32'h0100, 32'h0200};
  logic [32:0] ux [7] = '{33'hf0f0, 33'hf0ff, 33'h00ff, 33'h01fe, 33'h0101, 33'h1_0000_0101,
    33'h0101};
  sdp_datapath dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .mode(mode),
    .issueValid(issueValid), .issue(issue), .issueReady(issueReady), .memRData(memRData),
    .pmBusIn(pmBusIn), .dmBusIn(dmBusIn), .bufCfgWe(bufCfgWe), .bufCfgGen(bufCfgGen),
    .bufCfgBank(bufCfgBank), .bufCfgBuf(bufCfgBuf), .bufCfg(bufCfg), .ubOp(ubOp),
    .ubSel(ubSel), .ubOperand(ubOperand), .memReq(memReq), .firstFlags(firstFlags),
    .secondFlags(secondFlags), .pxData(pxData), .ubData(ubData), .ubTestHit(ubTestHit));
  sdp_mem_model mem (.core_clk(core_clk), .rst_n(rst_n), .memReq(memReq), .memRData(memRData));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic sdp_instr_s ins(sdp_alu_e op, int d, int a, int b, sdp_fmt_e f, bit m,
    int md);
    sdp_instr_s r;
    r = '0;
    r.aluOp = op;
    r.aluDst = 4'(d);
    r.aluSrcA = 4'(a);
    r.aluSrcB = 4'(b);
    r.fmt = f;
    r.mulEn = m;
    r.mulDst = 4'(md);
    r.mulSrcA = 4'(a);
    r.mulSrcB = 4'(b);
    return r;
  endfunction
  function automatic sdp_instr_s mi(sdp_mem_e op, int rg, bit g, sdp_px_e px);
    sdp_instr_s r;
    r = '0;
    r.memOp = op;
    r.memReg = 4'(rg);
    r.pxReg = 4'(rg);
    r.agGen = g;
    r.pxOp = px;
    return r;
  endfunction
  // Holds the request until taken; valid stays up so back-to-back calls work
  task automatic do_issue(input sdp_instr_s i, output int st);
    st = 0;
    issue = i;
    issueValid = 1'b1;
    #1;
    while (issueReady !== 1'b1)
    begin
      @(negedge core_clk);
      st++;
      if (st > 50)
      begin
        errors++;
        print_verdict();
      end
    end
    @(negedge core_clk);
  endtask
  task automatic idle();
    issueValid = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic ld(input int rg, input logic [31:0] ad);
    do_issue(mi(MEM_LOAD, rg, 1'b0, PX_NOP), s);
    chk(64'({memReq.valid, memReq.write, memReq.pair, memReq.addr}), 64'({3'h5, ad}));
  endtask
  // Stores go out through a 16-word circular buffer from zero that never wraps here, so the address is a running count
  task automatic st(input int rg, input logic pr, input logic [63:0] wd);
    do_issue(mi(MEM_STORE, rg, 1'b1, PX_NOP), s);
    chk(64'({memReq.valid, memReq.write, memReq.pair, memReq.addr}), 64'({2'h3, pr, 32'(sa)}));
    chk(memReq.wdata, wd);
    sa++;
  endtask
  task automatic cfg(input logic g, input logic [31:0] b, input logic [31:0] x);
    bufCfgWe = 1'b1;
    bufCfgGen = g;
    bufCfg = '{base: b, length: (g ? 32'h10 : 32'h3), modify: 32'h1, index: x};
    @(negedge core_clk);
    bufCfgWe = 1'b0;
    @(negedge core_clk);
  endtask
  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever
      #25 core_clk = ~core_clk;
  end
  initial
  begin
    {rst_n, issueValid, bufCfgWe, bufCfgGen, bufCfgBank, bufCfgBuf, ubSel} = '0;
    {errors, num_checks, sa} = '0;
    clkEn = 1'b1;
    mode = '0;
    issue = '0;
    bufCfg = '0;
    ubOp = UB_NOP;
    ubOperand = '0;
    pmBusIn = 64'h1122334455667788;
    dmBusIn = 64'h99aabbccddeeff00;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    chk(64'({issueReady, memReq.valid, ubTestHit, ubData}), 64'h4_0000_0000);
    chk(pxData, 64'h0);
    // Load buffer starts mid-range so the second step wraps to the base
    cfg(1'b0, 32'h8, 32'h9);
    cfg(1'b1, 32'h0, 32'h0);
    mode.secondEn = 1'b1;
    ld(1, 32'h9);
    ld(2, 32'ha);
    ld(3, 32'h8);
    do_issue(ins(ALU_ADD, 4, 1, 2, FMT_FIXED, 1'b1, 5), s);
    st(4, 1'b1, 64'h0000000c_00000005);
    st(5, 1'b1, 64'h00000023_00000006);
    w = ins(ALU_ADD, 4, 4, 1, FMT_FIXED, 1'b0, 0);
    w.yOnly = 1'b1;
    do_issue(w, s);
    st(4, 1'b1, 64'h00000011_00000005);
    do_issue(ins(ALU_SUB, 12, 1, 2, FMT_FIXED, 1'b0, 0), s);
    chk(64'({firstFlags, secondFlags}), 64'h1);
    idle();
    $display("simd test done");
    // Second element off: it must keep registers and flags
    mode.secondEn = 1'b0;
    do_issue(ins(ALU_SUB, 13, 2, 1, FMT_FIXED, 1'b0, 0), s);
    chk(64'({firstFlags, secondFlags}), 64'h5);
    do_issue(w, s);
    st(13, 1'b0, 64'h00000000_ffffffff);
    idle();
    mode.secondEn = 1'b1;
    st(13, 1'b1, 64'h00000000_ffffffff);
    st(1, 1'b1, 64'h00000005_00000003);
    idle();
    mode.dataBank = 1'b1;
    st(1, 1'b1, 64'h0);
    idle();
    mode.dataBank = 1'b0;
    // Secondary address set is still all zero, so the pointer reads zero
    mode.agBank = 1'b1;
    ld(7, 32'h0);
    idle();
    mode.agBank = 1'b0;
    $display("enable test done");
    // Producer then dependent reader; stall count follows the latency
    for (k = 0; k < 6; k++)
    begin
      do_issue(ins(lo[k], 14, 1, 2, lf[k], lm[k], 14), s);
      do_issue(ins(ALU_ADD, 15, 14, 1, FMT_FIXED, 1'b0, 15), s);
      chk(64'(s), 64'(le[k]));
    end
    // Multiply into the secondary result register
    mode.mulBank = 1'b1;
    do_issue(ins(ALU_NOP, 6, 1, 2, FMT_FIXED, 1'b1, 6), s);
    chk(64'(s), 64'h0);
    mode.mulBank = 1'b0;
    idle();
    $display("latency test done");
    // Universal register ops, read back one edge late
    ubSel = 2'h2;
    for (k = 0; k < 7; k++)
    begin
      ubOp = uo[k];
      ubOperand = uv[k];
      @(negedge core_clk);
      ubOp = UB_NOP;
      repeat (2) @(negedge core_clk);
      chk(64'({ubTestHit, ubData}), 64'(ux[k]));
    end
    $display("universal test done");
    mode.secondEn = 1'b0;
    do_issue(mi(MEM_NONE, 0, 1'b0, PX_FROM_PM), s);
    chk(pxData, 64'h1122334455667788);
    do_issue(mi(MEM_NONE, 10, 1'b0, PX_TO_REG), s);
    st(10, 1'b0, 64'h00000000_55667788);
    do_issue(mi(MEM_NONE, 0, 1'b0, PX_FROM_DM), s);
    chk(pxData, 64'h99aabbccddeeff00);
    do_issue(mi(MEM_NONE, 10, 1'b0, PX_FROM_REG), s);
    chk(pxData, 64'h00000044_55667788);
    idle();
    $display("exchange test done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
